// File: slsf_cfg.svh
// register map, reset values and field positions of the stage limit status flags
`ifndef SLSF_CFG_SVH
`define SLSF_CFG_SVH

// ----------------------------------------------------------------------------
// geometry
// ----------------------------------------------------------------------------
`define SLSF_NSTAGE      12
`define SLSF_DW          16
`define SLSF_AW          10

// ----------------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------------
`define SLSF_OFS_HIGH    10'h009
`define SLSF_OFS_DONE    10'h00a
`define SLSF_OFS_DONE_EN 10'h00b
`define SLSF_OFS_DONE_CL 10'h00c

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define SLSF_RST_FLAGS   12'h000
`define SLSF_RST_WORD    16'h0000
`define SLSF_PAD_ZERO    4'h0

`endif

// File: slsf_pkg.sv
// types shared by the stage limit status flags block
package slsf_pkg;
    // one stage event as reported by the conversion sequencer
    typedef struct packed {
        logic [11:0] over_high;
        logic [11:0] conv_done;
    } slsf_stage_evt_t;

    typedef enum logic [1:0] {
        SLSF_RD_NONE = 2'b00,
        SLSF_RD_HIGH = 2'b01,
        SLSF_RD_DONE = 2'b10,
        SLSF_RD_OTHR = 2'b11
    } slsf_rd_kind_t;
endpackage : slsf_pkg

// File: slsf_flag_bit.sv
// one sticky status flag with set-over-clear
`timescale 1ns/1ps
`default_nettype none
module slsf_flag_bit (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic set_i,
    input  wire logic clr_i,
    output var  logic flag_o
);
    logic flag_d;

    always_comb begin
        flag_d = flag_o;
        if (clr_i) begin
            flag_d = 1'b0;
        end
        if (set_i) begin
            flag_d = 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            flag_o <= 1'b0;
        end else begin
            flag_o <= flag_d;
        end
    end
endmodule : slsf_flag_bit
`default_nettype wire

// File: slsf_top.sv
// stage high-limit and conversion-done status flags with interrupt
//
// Design decision made here: strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "slsf_cfg.svh"

// Contract
// - high-limit flags, 0x009, bits 0-11, read-only
// - stage result above high threshold sets flag
// - readback clears flags unless limit still exceeded
// - per-stage read-only conversion-done flags, reset zero
// - enabled done flag drives active-low interrupt
module slsf_top
    import slsf_pkg::*;
(
    input  wire logic                   CORE_CLK,
    input  wire logic                   SYS_RST,
    input  wire logic [`SLSF_AW-1:0]    ADDR,
    input  wire logic [`SLSF_DW-1:0]    WDATA,
    input  wire logic                   WR_STB,
    input  wire logic                   RD_STB,
    input  wire slsf_stage_evt_t        STAGE_EVT,
    output var  logic [`SLSF_DW-1:0]    RDATA,
    output var  logic                   INT_N
);
    // ------------------------------------------------------------------------
    // flag storage
    // ------------------------------------------------------------------------
    logic [`SLSF_NSTAGE-1:0] high_flag;
    logic [`SLSF_NSTAGE-1:0] done_flag;
    logic [`SLSF_NSTAGE-1:0] high_clr;
    logic [`SLSF_NSTAGE-1:0] done_clr;
    logic [`SLSF_NSTAGE-1:0] done_en_q;
    logic [`SLSF_NSTAGE-1:0] done_en_d;
    logic                    en_wr;
    logic                    cl_wr;
    logic [`SLSF_DW-1:0]     rdata_d;
    logic                    int_n_d;
    slsf_rd_kind_t           rd_kind;

    // readback decode; only the read strobe cycle counts as readback, so a
    // stray address change between strobes never clears a flag
    always_comb begin
        rd_kind = SLSF_RD_NONE;
        if (RD_STB) begin
            case (ADDR)
                `SLSF_OFS_HIGH: rd_kind = SLSF_RD_HIGH;
                `SLSF_OFS_DONE: rd_kind = SLSF_RD_DONE;
                default:        rd_kind = SLSF_RD_OTHR;
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // write decode
    // ------------------------------------------------------------------------
    // only the enable and clear words take writes; a write to either status
    // word, or to any unmapped address, falls through and changes nothing
    assign en_wr = WR_STB && (ADDR == `SLSF_OFS_DONE_EN);
    assign cl_wr = WR_STB && (ADDR == `SLSF_OFS_DONE_CL);

    // ------------------------------------------------------------------------
    // clear strobes
    // ------------------------------------------------------------------------
    // high flags cleared on readback; a limit still exceeded re-sets the flag
    // because set beats clear in every flag cell
    assign high_clr = (rd_kind == SLSF_RD_HIGH) ?
                      {`SLSF_NSTAGE{1'b1}} : `SLSF_RST_FLAGS;
    // done flags ignore readback: software clears them by writing ones, so
    // a status poll can never swallow a completion it has not handled
    assign done_clr = cl_wr ? WDATA[`SLSF_NSTAGE-1:0] : `SLSF_RST_FLAGS;

    // ------------------------------------------------------------------------
    // per-stage flag cells
    // ------------------------------------------------------------------------
    // high and done cells are identical and differ only in how they clear
    for (genvar i = 0; i < `SLSF_NSTAGE; i++) begin : g_stage
        slsf_flag_bit u_high (
            .clk    (CORE_CLK),
            .rst    (SYS_RST),
            .set_i  (STAGE_EVT.over_high[i]),
            .clr_i  (high_clr[i]),
            .flag_o (high_flag[i])
        );
        slsf_flag_bit u_done (
            .clk    (CORE_CLK),
            .rst    (SYS_RST),
            .set_i  (STAGE_EVT.conv_done[i]),
            .clr_i  (done_clr[i]),
            .flag_o (done_flag[i])
        );
    end

    // ------------------------------------------------------------------------
    // registers, read data and interrupt
    // ------------------------------------------------------------------------
    always_comb begin
        done_en_d = done_en_q;
        if (en_wr) begin
            done_en_d = WDATA[`SLSF_NSTAGE-1:0];
        end
        // unmapped and write-only addresses read back as zero
        rdata_d = `SLSF_RST_WORD;
        case (rd_kind)
            SLSF_RD_HIGH: rdata_d = {`SLSF_PAD_ZERO, high_flag};
            SLSF_RD_DONE: rdata_d = {`SLSF_PAD_ZERO, done_flag};
            SLSF_RD_OTHR: begin
                if (ADDR == `SLSF_OFS_DONE_EN) begin
                    rdata_d = {`SLSF_PAD_ZERO, done_en_q};
                end
            end
            default: rdata_d = `SLSF_RST_WORD;
        endcase
        // a level, not a pulse: it stays low until the host clears the
        // flag or drops its enable, so a slow host cannot miss it
        int_n_d = ~|(done_flag & done_en_q);
    end

    always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            done_en_q  <= `SLSF_RST_FLAGS;
            RDATA      <= `SLSF_RST_WORD;
            INT_N      <= 1'b1;
        end else begin
            done_en_q  <= done_en_d;
            RDATA      <= rdata_d;
            INT_N      <= int_n_d;
        end
    end

    // ------------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------------
    // checks are vector-wide, so every stage is watched rather than one
    // sample bit that a test may never touch
    sequence s_high_read;
        RD_STB && ADDR == `SLSF_OFS_HIGH;
    endsequence

    sequence s_done_read;
        RD_STB && ADDR == `SLSF_OFS_DONE;
    endsequence

    // a write aimed at the high-limit word with no read beside it
    sequence s_high_write;
        WR_STB && !RD_STB && ADDR == `SLSF_OFS_HIGH;
    endsequence

    // a completion lands on an enabled stage, and one cycle later an
    // enabled done flag stands
    sequence s_done_enabled;
        |(STAGE_EVT.conv_done & done_en_q) ##1 |(done_flag & done_en_q);
    endsequence

    high_set_a: assert property (
        @(posedge CORE_CLK) disable iff (SYS_RST)
        |STAGE_EVT.over_high |=>
        &(high_flag | ~$past(STAGE_EVT.over_high)))
        else $error("high flag not set by over-limit");

    high_clear_a: assert property (
        @(posedge CORE_CLK) disable iff (SYS_RST)
        s_high_read |=>
        (high_flag & ~$past(STAGE_EVT.over_high)) == `SLSF_RST_FLAGS)
        else $error("high flag not cleared on readback");

    high_keep_a: assert property (
        @(posedge CORE_CLK) disable iff (SYS_RST)
        s_high_read |=> (high_flag & $past(STAGE_EVT.over_high))
            == $past(STAGE_EVT.over_high))
        else $error("high flag lost while limit exceeded");

    high_readback_a: assert property (
        @(posedge CORE_CLK) disable iff (SYS_RST)
        s_high_read |=>
        RDATA[`SLSF_NSTAGE-1:0] == $past(high_flag))
        else $error("high register readback wrong");

    high_write_a: assert property (
        @(posedge CORE_CLK) disable iff (SYS_RST)
        s_high_write |=>
        high_flag == ($past(high_flag) | $past(STAGE_EVT.over_high)))
        else $error("write changed the high flags");

    upper_zero_a: assert property (
        @(posedge CORE_CLK) disable iff (SYS_RST)
        RDATA[`SLSF_DW-1:`SLSF_NSTAGE] == `SLSF_PAD_ZERO)
        else $error("upper bits not zero");

    done_set_a: assert property (
        @(posedge CORE_CLK) disable iff (SYS_RST)
        |STAGE_EVT.conv_done |=>
        &(done_flag | ~$past(STAGE_EVT.conv_done)))
        else $error("done flag not set");

    done_readback_a: assert property (
        @(posedge CORE_CLK) disable iff (SYS_RST)
        s_done_read |=>
        RDATA[`SLSF_NSTAGE-1:0] == $past(done_flag))
        else $error("done register readback wrong");

    done_keep_a: assert property (
        @(posedge CORE_CLK) disable iff (SYS_RST)
        s_done_read |=>
        &(done_flag | ~$past(done_flag)))
        else $error("done flag lost on readback");

    irq_assert_a: assert property (
        @(posedge CORE_CLK) disable iff (SYS_RST)
        s_done_enabled |=> !INT_N)
        else $error("interrupt not asserted");

    irq_quiet_a: assert property (
        @(posedge CORE_CLK) disable iff (SYS_RST)
        (done_en_q == `SLSF_RST_FLAGS) |=> INT_N)
        else $error("interrupt with no source enabled");

    irq_release_a: assert property (
        @(posedge CORE_CLK) disable iff (SYS_RST)
        !(|(done_flag & done_en_q)) |=> INT_N)
        else $error("interrupt held with no enabled flag");
endmodule : slsf_top
`default_nettype wire

// File: slsf_seq_model.sv
// conversion sequencer stand-in that drives the stage event struct
`timescale 1ns/1ps
`default_nettype none
module slsf_seq_model
    import slsf_pkg::*;
(
    input  wire logic [11:0]     over_req,
    input  wire logic [11:0]     done_req,
    output var  slsf_stage_evt_t evt
);
    // passed straight through so the bench owns the exact event cycle
    always_comb begin
        evt.over_high = over_req;
        evt.conv_done = done_req;
    end
endmodule : slsf_seq_model
`default_nettype wire

// File: tb_stage_limit_status_flags.sv
// self-checking bench for the stage limit status flags block
`timescale 1ns/1ps
`default_nettype none
`include "slsf_cfg.svh"
module tb_stage_limit_status_flags
    import slsf_pkg::*;
;
    logic            clk = 0, rst = 1, wr = 0, rd = 0, rd_seen = 0;
    logic [9:0]      addr = '0;
    logic [15:0]     wd = '0, rdata, exp_q[$];
    logic [11:0]     over = '0, done = '0, m;
    logic            int_n;
    slsf_stage_evt_t evt;
    int              err_total = 0, n_checks = 0, cyc = 0;
    always #4 clk = ~clk;
    slsf_seq_model i_slsf_seq_model (.over_req(over), .done_req(done),
        .evt(evt));
    slsf_top i_slsf_top (.CORE_CLK(clk), .SYS_RST(rst), .ADDR(addr),
        .WDATA(wd), .WR_STB(wr), .RD_STB(rd), .STAGE_EVT(evt),
        .RDATA(rdata), .INT_N(int_n));
    // ------------------------------------------------------------
    // bus tasks and scoreboard
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [15:0] s, e);
        n_checks++;
        if (s !== e) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    task automatic rdx(input logic [9:0] a, input logic [15:0] e);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        exp_q.push_back(e);
        @(posedge clk);
        rd <= 1'b0;
    endtask : rdx
    task automatic wrx(input logic [9:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wd   <= d;
        wr   <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wrx
    task automatic irq(input logic e);
        repeat (3) @(posedge clk);
        #1 chk("int_n", {15'h0, int_n}, {15'h0, e});
    endtask : irq
    task automatic give_verdict;
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : give_verdict
    // read data stands only in the cycle after the strobe
    always @(posedge clk) rd_seen <= rd;
    always @(negedge clk) if (rd_seen)
        chk("rdata", rdata, exp_q.pop_front());
    always @(posedge clk) begin
        cyc++;
        if (cyc > 2000) begin
            err_total++;
            give_verdict();
        end
    end
    initial begin
        void'($urandom(32'hfd4c));
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        rdx(`SLSF_OFS_HIGH, 16'h0000);
        rdx(`SLSF_OFS_DONE, 16'h0000);
        for (int i = 0; i < 4; i++) begin
            m = 12'($urandom);
            @(posedge clk) over <= m;
            @(posedge clk) over <= '0;
            rdx(`SLSF_OFS_HIGH, {4'h0, m});
            rdx(`SLSF_OFS_HIGH, 16'h0000);
        end
        @(posedge clk) over <= 12'h808;
        rdx(`SLSF_OFS_HIGH, 16'h0808);
        rdx(`SLSF_OFS_HIGH, 16'h0808);
        @(posedge clk) over <= '0;
        rdx(`SLSF_OFS_HIGH, 16'h0808);
        rdx(`SLSF_OFS_HIGH, 16'h0000);
        wrx(`SLSF_OFS_HIGH, 16'hffff);
        rdx(`SLSF_OFS_HIGH, 16'h0000);
        rdx(10'h3ff, 16'h0000);
        wrx(`SLSF_OFS_DONE_EN, 16'h0004);
        rdx(`SLSF_OFS_DONE_EN, 16'h0004);
        rdx(`SLSF_OFS_DONE_CL, 16'h0000);
        @(posedge clk) done <= 12'h020;
        @(posedge clk) done <= '0;
        irq(1'b1);
        @(posedge clk) done <= 12'h004;
        @(posedge clk) done <= '0;
        irq(1'b0);
        rdx(`SLSF_OFS_DONE, 16'h0024);
        rdx(`SLSF_OFS_DONE, 16'h0024);
        wrx(`SLSF_OFS_DONE_CL, 16'h0024);
        irq(1'b1);
        rdx(`SLSF_OFS_DONE, 16'h0000);
        // set every flag, then reset mid-run: flags and enables must return to zero, INT_N high
        @(posedge clk) done <= 12'hfff;
        over <= 12'hfff;
        @(posedge clk) done <= '0;
        over <= '0;
        rst  <= 1'b1;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        rdx(`SLSF_OFS_HIGH, 16'h0000);
        rdx(`SLSF_OFS_DONE, 16'h0000);
        rdx(`SLSF_OFS_DONE_EN, 16'h0000);
        irq(1'b1);
        repeat (2) @(posedge clk);
        give_verdict();
    end
endmodule : tb_stage_limit_status_flags
`default_nettype wire
